// ### design/qbsd_core.sv
// sdram core: link sampling, bank and burst engine, apb registers
`default_nettype none
module qbsd_core
	import qbsd_pkg::*;
(
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// memory link inputs
	input wire logic sd_clk,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [BANK_W-1:0] bank_sel,
	input wire logic [ROW_W-1:0] addr,
	input wire logic [MASK_W-1:0] byte_mask,
	// data lines, split
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic [MASK_W-1:0] data_oe_n
);
	qbsd_pins_t pin_s;
	qbsd_cmd_t cmd;
	qbsd_pwr_t pwr_ff;
	logic clk_s;
	logic clk_prev_ff;
	logic lnk_edge;
	logic adv;
	logic cmd_v;
	logic ctrl_en_ff;
	logic [ROW_W-1:0] mode_ff;
	logic [BANKS-1:0] open_ff;
	logic [ROW_W-1:0] row_ff [BANKS];
	logic brst_ff;
	logic bwr_ff;
	logic bap_ff;
	logic [BANK_W-1:0] bbank_ff;
	logic [BANK_W-1:0] ap_bank;
	logic [COL_W-1:0] bcol_ff;
	logic [COL_W-1:0] bcnt_ff;
	logic [COL_W-1:0] blast_ff;
	logic [COL_W-1:0] len_m1;
	logic [COL_W-1:0] start_last;
	logic [COL_W-1:0] col_cur;
	logic start;
	logic pre_hit;
	logic stop;
	logic step;
	logic burst_end;
	logic ap_now;
	logic cl3;
	logic mem_rd;
	logic mem_wr;
	logic [MEM_AW-1:0] mem_addr;
	logic [MASK_W-1:0] mem_be;
	logic [DATA_W-1:0] mem_rdata;
	logic [DATA_W-1:0] st0_ff;
	logic [DATA_W-1:0] st1_ff;
	logic rd_cap_ff;
	logic rv0_ff;
	logic rv1_ff;
	logic [MASK_W-1:0] mask_d1_ff;
	logic [REF_W-1:0] refcnt_ff;
	logic ref_evt;
	logic apb_setup;
	logic apb_wr;
	logic hit;
	logic [31:0] rd_mux;

	qbsd_sync #(.W(PINS_W)) u_sync_pins (
		.pclk(pclk),
		.presetn(presetn),
		.d({cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr, byte_mask,
			data_in}),
		.sync_ff(pin_s)
	);

	qbsd_sync #(.W(1)) u_sync_clk (
		.pclk(pclk),
		.presetn(presetn),
		.d(sd_clk),
		.sync_ff(clk_s)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev_ff <= 1'h0;
		end else begin
			clk_prev_ff <= clk_s;
		end
	end

	// link edges, gated by clock enable and power state
	assign lnk_edge = clk_s & ~clk_prev_ff;
	assign adv = lnk_edge & pin_s.cke & (pwr_ff == PWR_RUN);
	assign cmd = qbsd_cmd_t'({pin_s.ras_n, pin_s.cas_n, pin_s.we_n});
	assign cmd_v = adv & ~pin_s.cs_n & ctrl_en_ff;

	// mode fields
	assign cl3 = mode_ff[CL_LSB +: 3] == CL_THREE;
	assign len_m1 = mode_ff[BL_LSB + 2] ? FULL_M1 :
		COL_W'((CNT_ONE << mode_ff[BL_LSB +: 2]) - CNT_ONE);
	assign start_last = (cmd == CMD_WR && mode_ff[WB_BIT]) ? '0 :
		len_m1;

	// burst control
	assign start = cmd_v & (cmd == CMD_RD | cmd == CMD_WR) &
		open_ff[pin_s.bank_sel];
	assign pre_hit = cmd_v & (cmd == CMD_PRE) &
		(pin_s.addr[AP_BIT] | (pin_s.bank_sel == bbank_ff));
	assign stop = (cmd_v & (cmd == CMD_BST)) | pre_hit;
	assign step = adv & brst_ff & ~start & ~stop;
	assign burst_end = step & (bcnt_ff == blast_ff);
	assign col_cur = mode_ff[BT_BIT] ? (bcol_ff ^ bcnt_ff) :
		((bcol_ff & ~blast_ff) | ((bcol_ff + bcnt_ff) & blast_ff));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brst_ff <= 1'h0;
			bwr_ff <= 1'h0;
			bap_ff <= 1'h0;
			bbank_ff <= '0;
			bcol_ff <= '0;
			bcnt_ff <= '0;
			blast_ff <= '0;
		end else if (start) begin
			// a read or write to an open bank restarts generation
			brst_ff <= start_last != '0;
			bwr_ff <= cmd == CMD_WR;
			bap_ff <= pin_s.addr[AP_BIT];
			bbank_ff <= pin_s.bank_sel;
			bcol_ff <= pin_s.addr[COL_W-1:0];
			bcnt_ff <= CNT_ONE;
			blast_ff <= start_last;
		end else if (stop | burst_end) begin
			brst_ff <= 1'h0;
		end else if (step) begin
			bcnt_ff <= bcnt_ff + CNT_ONE;
		end
	end

	// array access for the current link edge
	assign mem_be = ~pin_s.byte_mask;
	always_comb begin
		mem_rd = 1'h0;
		mem_wr = 1'h0;
		mem_addr = {bbank_ff, row_ff[bbank_ff], col_cur};
		if (start) begin
			mem_rd = cmd == CMD_RD;
			mem_wr = cmd == CMD_WR;
			mem_addr = {pin_s.bank_sel, row_ff[pin_s.bank_sel],
				pin_s.addr[COL_W-1:0]};
		end else if (step) begin
			mem_rd = ~bwr_ff;
			mem_wr = bwr_ff;
		end
	end

	qbsd_mem #(.AW(MEM_AW), .DW(DATA_W)) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.rd_en(mem_rd),
		.wr_en(mem_wr),
		.addr(mem_addr),
		.be(mem_be),
		.wdata(pin_s.data),
		.rdata_ff(mem_rdata)
	);

	// bank rows
	assign ap_now = (start & (start_last == '0) & pin_s.addr[AP_BIT]) |
		(burst_end & bap_ff);
	assign ap_bank = start ? pin_s.bank_sel : bbank_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_ff <= '0;
			for (int i = 0; i < BANKS; i++) begin
				row_ff[i] <= '0;
			end
		end else begin
			if (ap_now) begin
				open_ff[ap_bank] <= 1'h0;
			end
			if (cmd_v && cmd == CMD_ACT) begin
				open_ff[pin_s.bank_sel] <= 1'h1;
				row_ff[pin_s.bank_sel] <= pin_s.addr;
			end
			if (cmd_v && cmd == CMD_PRE) begin
				if (pin_s.addr[AP_BIT]) begin
					open_ff <= '0;
				end else begin
					open_ff[pin_s.bank_sel] <= 1'h0;
				end
			end
		end
	end

	// mode register and low-power states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= MODE_RST;
		end else if (cmd_v && cmd == CMD_MRS && !brst_ff) begin
			mode_ff <= pin_s.addr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_ff <= PWR_RUN;
		end else if (lnk_edge) begin
			case (pwr_ff)
				PWR_RUN: begin
					if (!pin_s.cke) begin
						if (!pin_s.cs_n && cmd == CMD_REF) begin
							pwr_ff <= PWR_SELF;
						end else if (brst_ff) begin
							pwr_ff <= PWR_SUSP;
						end else begin
							pwr_ff <= PWR_DOWN;
						end
					end
				end
				PWR_DOWN, PWR_SUSP, PWR_SELF: begin
					if (pin_s.cke) begin
						pwr_ff <= PWR_RUN;
					end
				end
				default: begin
					pwr_ff <= PWR_RUN;
				end
			endcase
		end
	end

	// read pipeline, launched one link edge ahead of capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_cap_ff <= 1'h0;
			rv0_ff <= 1'h0;
			rv1_ff <= 1'h0;
			st0_ff <= '0;
			st1_ff <= '0;
			mask_d1_ff <= '0;
			data_out <= '0;
			data_oe_n <= '1;
		end else begin
			rd_cap_ff <= mem_rd;
			if (rd_cap_ff) begin
				st0_ff <= mem_rdata;
			end
			if (adv) begin
				rv0_ff <= mem_rd;
				rv1_ff <= rv0_ff;
				st1_ff <= st0_ff;
				mask_d1_ff <= pin_s.byte_mask;
				data_out <= cl3 ? st1_ff : st0_ff;
				data_oe_n <= ~{MASK_W{cl3 ? rv1_ff : rv0_ff}} |
					mask_d1_ff;
			end
		end
	end

	// apb slave, answer in the first access cycle
	assign ref_evt = cmd_v & (cmd == CMD_REF);
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pready & pwrite & ~pslverr;
	assign hit = (paddr == REG_CTRL) | (paddr == REG_STATUS) |
		(paddr == REG_REFCNT);

	always_comb begin
		case (paddr)
			REG_CTRL: rd_mux = {31'h0000_0000, ctrl_en_ff};
			REG_STATUS: rd_mux = {13'h0000, mode_ff, bwr_ff, brst_ff,
				pwr_ff, open_ff};
			REG_REFCNT: rd_mux = {16'h0000, refcnt_ff};
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= '0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~hit;
			if (apb_setup) begin
				prdata <= pwrite ? '0 : rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_ff <= CTRL_EN_RST;
		end else if (apb_wr && paddr == REG_CTRL) begin
			ctrl_en_ff <= pwdata[CTRL_EN_BIT];
		end
	end

	// refresh count; a refresh in the same cycle as a clear leaves the count at one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refcnt_ff <= '0;
		end else if (ref_evt) begin
			refcnt_ff <= (apb_wr && paddr == REG_REFCNT) ?
				REF_W'(1) : refcnt_ff + REF_W'(1);
		end else if (apb_wr && paddr == REG_REFCNT) begin
			refcnt_ff <= '0;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_act;
		cmd_v && cmd == CMD_ACT;
	endsequence
	sequence s_last_step;
		step && bcnt_ff == blast_ff;
	endsequence

	property p_act_opens;
		s_act |=> open_ff[$past(pin_s.bank_sel)];
	endproperty

	chk_act_opens: assert property (p_act_opens)
		else $error("activate did not open the bank");
	chk_col_start: assert property (
		start |-> mem_addr[COL_W-1:0] == pin_s.addr[COL_W-1:0])
		else $error("burst did not start at given column");
	chk_burst_ends: assert property (
		s_last_step |=> !brst_ff)
		else $error("burst ran past its length");
	chk_auto_close: assert property (
		s_last_step ##0 bap_ff |=> !open_ff[$past(bbank_ff)])
		else $error("auto precharge left row open");
	chk_stop_burst: assert property (
		stop |=> !brst_ff)
		else $error("burst survived stop or precharge");
	chk_read_lat_two: assert property (
		adv && !cl3 && rv0_ff && mask_d1_ff == 4'h0
		|=> data_oe_n == 4'h0 && data_out == $past(st0_ff))
		else $error("latency two data missing");
	chk_read_lat_three: assert property (
		adv && cl3 && rv1_ff && mask_d1_ff == 4'h0
		|=> data_oe_n == 4'h0 && data_out == $past(st1_ff))
		else $error("latency three data missing");
	chk_wr_mask: assert property (
		mem_wr |-> mem_be == ~pin_s.byte_mask)
		else $error("masked byte written");
	chk_deselect: assert property (
		adv && pin_s.cs_n && !brst_ff |=> $stable(open_ff) &&
		$stable(mode_ff))
		else $error("deselected command took effect");
	chk_edge_only: assert property (
		!lnk_edge |=> $stable(open_ff) && $stable(bcnt_ff))
		else $error("state moved without a link edge");
	chk_cke_freeze: assert property (
		lnk_edge && !pin_s.cke |=> $stable(bcnt_ff) ##1 $stable(bcnt_ff))
		else $error("burst advanced with clock disabled");
	chk_self_ref: assert property (
		lnk_edge && pwr_ff == PWR_RUN && !pin_s.cke && !pin_s.cs_n &&
		cmd == CMD_REF |=> pwr_ff == PWR_SELF)
		else $error("self refresh not entered");
	chk_other_bank: assert property (
		pre_hit == 1'h0 && cmd_v && cmd == CMD_PRE && brst_ff &&
		!(bcnt_ff == blast_ff) |=> brst_ff)
		else $error("precharge of other bank broke burst");
endmodule
`default_nettype wire

// ### design/qbsd_pkg.sv
// constants and types of the four-bank sdram core
`default_nettype none
package qbsd_pkg;
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROW_W = 11;
	localparam int COL_W = 8;
	localparam int DATA_W = 32;
	localparam int MASK_W = 4;
	localparam int MEM_AW = BANK_W + ROW_W + COL_W;
	localparam int REF_W = 16;
	localparam int APB_AW = 12;
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_REFCNT = 12'h008;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'h1;
	localparam int BL_LSB = 0;
	localparam int BT_BIT = 3;
	localparam int CL_LSB = 4;
	localparam int WB_BIT = 9;
	localparam int AP_BIT = 10;
	localparam logic [2:0] CL_THREE = 3'h3;
	localparam logic [10:0] MODE_RST = 11'h020;
	localparam logic [7:0] FULL_M1 = 8'hff;
	localparam logic [7:0] CNT_ONE = 8'h01;
	typedef enum logic [2:0] {
		CMD_MRS = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} qbsd_cmd_t;
	typedef enum logic [1:0] {
		PWR_RUN = 2'h0,
		PWR_DOWN = 2'h1,
		PWR_SUSP = 2'h2,
		PWR_SELF = 2'h3
	} qbsd_pwr_t;
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] bank_sel;
		logic [10:0] addr;
		logic [3:0] byte_mask;
		logic [31:0] data;
	} qbsd_pins_t;
	localparam int PINS_W = $bits(qbsd_pins_t);
endpackage
`default_nettype wire

// ### design/qbsd_sync.sv
// two-flop synchroniser for a group of link pins
`default_nettype none
module qbsd_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// levels from the link
	input wire logic [W-1:0] d,
	output logic [W-1:0] sync_ff
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ### design/qbsd_mem.sv
// storage array with byte-lane writes and registered read data
`default_nettype none
module qbsd_mem #(
	parameter int AW = 21,
	parameter int DW = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// access port
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [AW-1:0] addr,
	input wire logic [DW/8-1:0] be,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_ff
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			for (int i = 0; i < DW / 8; i++) begin
				if (be[i]) begin
					mem[addr][8*i +: 8] <= wdata[8*i +: 8];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= '0;
		end else if (rd_en) begin
			rdata_ff <= mem[addr];
		end
	end
endmodule
`default_nettype wire

// ### sim/qbsd_ctl.sv
// controller model driving the sdram link and capturing read data
`default_nettype none
module qbsd_ctl
	import qbsd_pkg::*;
(
	// clock
	input wire logic pclk,
	// link outputs
	output logic sd_clk,
	output var qbsd_pins_t pins,
	// data lines as resolved on the board
	input wire logic [DATA_W-1:0] data_out,
	input wire logic [MASK_W-1:0] data_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] cap_d;
	logic [MASK_W-1:0] cap_oe;
	initial begin
		sd_clk = 1'b0;
		pins = '1;
		cap_d = '0;
		cap_oe = '0;
	end
	// one link period, pins change only while the clock is low
	task automatic cmd(input logic [3:0] c, input logic [1:0] b,
			input logic [10:0] a, input logic [3:0] m,
			input logic [31:0] d, input logic w, input logic ce = 1'b1);
		@(posedge pclk);
		sd_clk <= 1'b0;
		pins.cke <= ce;
		{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
		pins.bank_sel <= b;
		pins.addr <= a;
		pins.byte_mask <= m;
		// released lines toggle so stale data never looks valid
		pins.data <= w ? d : ~pins.data;
		repeat (4) @(posedge pclk);
		sd_clk <= 1'b1;
		cap_d = data_out;
		cap_oe = data_oe_n;
		repeat (3) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// self-checking bench of the sdram core with a controller model
`default_nettype none
module tb
	import qbsd_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] NOP = {1'b0, CMD_NOP}, RD = {1'b0, CMD_RD};
	localparam logic [3:0] WR = {1'b0, CMD_WR}, ACT = {1'b0, CMD_ACT};
	localparam logic [3:0] PRE = {1'b0, CMD_PRE}, BST = {1'b0, CMD_BST};
	localparam logic [3:0] REF = {1'b0, CMD_REF}, MRS = {1'b0, CMD_MRS};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sd_clk;
	logic err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, lfsr, dq;
	logic [31:0] mem [256];
	logic [10:0] cur_mode;
	qbsd_pins_t pins;
	logic [31:0] data_out;
	logic [3:0] data_oe_n;
	int errors, cmp_count;
	qbsd_core u_qbsd_core (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sd_clk(sd_clk),
		.cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
		.cas_n(pins.cas_n), .we_n(pins.we_n), .bank_sel(pins.bank_sel),
		.addr(pins.addr), .byte_mask(pins.byte_mask), .data_in(dq),
		.data_out(data_out), .data_oe_n(data_oe_n)
	);
	qbsd_ctl u_qbsd_ctl (
		.pclk(pclk), .sd_clk(sd_clk), .pins(pins), .data_out(dq),
		.data_oe_n(data_oe_n)
	);
	// memory wins each byte lane it enables
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dq[8*i+:8] = data_oe_n[i] ? pins.data[8*i+:8] : data_out[8*i+:8];
		end
	end
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic complete_run();
		if (errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [31:0] bmask(input logic [3:0] m);
		return ~{{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction
	function automatic logic [31:0] st(input logic [3:0] o,
			input logic [1:0] p);
		return {13'h0, cur_mode, 2'b00, p, o};
	endfunction
	function automatic logic [7:0] col_of(input logic [7:0] s, input int i,
			input int bl, input logic il);
		logic [7:0] k;
		k = 8'(bl - 1);
		return il ? (s ^ 8'(i)) : ((s & ~k) | ((s + 8'(i)) & k));
	endfunction
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			errors++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(rd, e);
	endtask
	task automatic lk(input logic [3:0] c, input logic [1:0] b,
			input logic [10:0] a, input logic [3:0] m = '0,
			input logic [31:0] d = '0, input logic w = 1'b0);
		u_qbsd_ctl.cmd(c, b, a, m, d, w);
	endtask
	task automatic mode(input logic [2:0] bc, input logic il,
			input logic l3, input logic wb);
		cur_mode = {1'b0, wb, 2'b00, l3 ? 3'h3 : 3'h2, il, bc};
		lk(MRS, 2'h0, cur_mode);
	endtask
	task automatic wr(input logic [7:0] c, input int bl, input logic il,
			input logic [3:0] m, input int n);
		logic [31:0] d;
		logic [7:0] k;
		for (int i = 0; i < bl; i++) begin
			d = rnd();
			k = col_of(c, i, bl, il);
			if (i < n) mem[k] = (mem[k] & ~bmask(m)) | (d & bmask(m));
			lk(i == 0 ? WR : NOP, 2'h1, {3'h0, c}, m, d, 1'b1);
		end
	endtask
	task automatic rdb(input logic [7:0] c, input int bl, input int l,
			input logic il, input logic [3:0] m, input logic ap);
		lk(RD, 2'h1, {ap, 2'h0, c}, m);
		for (int j = 1; j <= l + bl; j++) begin
			lk(NOP, 2'h1, 11'h000, m);
			if (j == l + bl) chk({28'h0, cap_oe()}, 32'hf);
			else if (j >= l) begin
				chk(u_qbsd_ctl.cap_d & bmask(m),
					mem[col_of(c, j - l, bl, il)] & bmask(m));
				chk({28'h0, cap_oe()}, {28'h0, m});
			end
		end
	endtask
	function automatic logic [3:0] cap_oe();
		return u_qbsd_ctl.cap_oe;
	endfunction
	initial begin
		logic [10:0] row;
		logic [3:0] r;
		errors = 0;
		cmp_count = 0;
		lfsr = 32'h0000_a4b7;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		cur_mode = MODE_RST;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rchk(REG_CTRL, 32'h1);
		rchk(REG_STATUS, st(4'h0, 2'h0));
		apb(1'b0, 12'h00c, '0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, REG_STATUS, '1);
		rchk(REG_STATUS, st(4'h0, 2'h0));
		repeat (3) lk(REF, 2'h0, 11'h000);
		lk({1'b1, CMD_REF}, 2'h0, 11'h000);
		apb(1'b1, REG_CTRL, 32'h0);
		lk(REF, 2'h0, 11'h000);
		apb(1'b1, REG_CTRL, 32'h1);
		rchk(REG_REFCNT, 32'h3);
		apb(1'b1, REG_REFCNT, '0);
		u_qbsd_ctl.cmd(NOP, 2'h0, 11'h000, 4'h0, '0, 1'b0, 1'b0);
		rchk(REG_STATUS, st(4'h0, 2'h1));
		lk(REF, 2'h0, 11'h000);
		rchk(REG_REFCNT, 32'h0);
		u_qbsd_ctl.cmd(REF, 2'h0, 11'h000, 4'h0, '0, 1'b0, 1'b0);
		rchk(REG_STATUS, st(4'h0, 2'h3));
		lk(NOP, 2'h0, 11'h000);
		rchk(REG_STATUS, st(4'h0, 2'h0));
		row = 11'(rnd());
		mode(3'h3, 1'b0, 1'b0, 1'b0);
		lk(ACT, 2'h1, row);
		wr(8'h00, 8, 1'b0, 4'h0, 8);
		rdb(8'h00, 8, 2, 1'b0, 4'h0, 1'b0);
		for (int t = 0; t < 6; t++) begin
			r = 4'(rnd());
			mode({1'b0, r[1:0]}, r[2], r[3], t[0]);
			wr({5'h0, 3'(rnd())}, 1 << r[1:0], r[2], 4'(rnd()),
				t[0] ? 1 : 1 << r[1:0]);
			rdb({5'h0, 3'(rnd())}, 1 << r[1:0], r[3] ? 3 : 2, r[2],
				4'(rnd()), 1'b0);
		end
		// full page: whole row, wrapping past the top column
		mode(3'h4, 1'b0, 1'b0, 1'b0);
		wr(8'hfe, 256, 1'b0, 4'h0, 256);
		rdb(8'hfe, 256, 2, 1'b0, 4'h0, 1'b0);
		// clock suspend in mid burst, exit edge consumed
		lk(RD, 2'h1, 11'h000);
		u_qbsd_ctl.cmd(NOP, 2'h1, 11'h000, 4'h0, '0, 1'b0, 1'b0);
		rchk(REG_STATUS, st(4'h2, 2'h2) | 32'h0000_0040);
		lk(BST, 2'h1, 11'h000);
		lk(BST, 2'h1, 11'h000);
		lk(NOP, 2'h1, 11'h000);
		chk(u_qbsd_ctl.cap_d, mem[0]);
		lk(NOP, 2'h1, 11'h000);
		chk({28'h0, cap_oe()}, 32'hf);
		rchk(REG_STATUS, st(4'h2, 2'h0));
		mode(3'h2, 1'b0, 1'b0, 1'b0);
		lk(RD, 2'h1, 11'h000);
		lk(RD, 2'h1, 11'h004);
		for (int j = 0; j < 5; j++) begin
			lk(NOP, 2'h1, 11'h000);
			chk(u_qbsd_ctl.cap_d, mem[j == 0 ? 0 : 3 + j]);
		end
		mode(3'h3, 1'b0, 1'b0, 1'b0);
		for (int t = 0; t < 2; t++) begin
			lk(RD, 2'h1, 11'h000);
			lk(NOP, 2'h1, 11'h000);
			rchk(REG_STATUS, st(4'h2, 2'h0) | 32'h0000_0040);
			lk(t ? PRE : BST, 2'h1, 11'h000);
			chk(u_qbsd_ctl.cap_d, mem[0]);
			lk(NOP, 2'h1, 11'h000);
			chk(u_qbsd_ctl.cap_d, mem[1]);
			lk(NOP, 2'h1, 11'h000);
			chk({28'h0, cap_oe()}, 32'hf);
		end
		rchk(REG_STATUS, st(4'h0, 2'h0));
		mode(3'h1, 1'b0, 1'b0, 1'b0);
		lk(ACT, 2'h1, row);
		rdb(8'h02, 2, 2, 1'b0, 4'h0, 1'b1);
		rchk(REG_STATUS, st(4'h0, 2'h0));
		lk(ACT, 2'h1, row);
		lk(ACT, 2'h2, row ^ 11'h7ff);
		lk(ACT, 2'h0, row);
		lk(RD, 2'h1, 11'h000);
		lk(PRE, 2'h2, 11'h000);
		for (int j = 0; j < 2; j++) begin
			lk(NOP, 2'h1, 11'h000);
			chk(u_qbsd_ctl.cap_d, mem[j]);
		end
		rchk(REG_STATUS, st(4'h3, 2'h0));
		lk(PRE, 2'h0, 11'h400);
		rchk(REG_STATUS, st(4'h0, 2'h0));
		complete_run();
	end
endmodule
`default_nettype wire
